/* rf_fastlock_serial_rx.sv */
// Shared constants for the fastlock control block and its three-wire serial word receiver.
`default_nettype none

package rf_fastlock_pkg;
  localparam int           WORD_W         = 24;
  localparam int           CTRL_W         = 4;
  localparam logic [3:0]   CTRL_FASTLOCK  = 4'hD;
  localparam logic [3:0]   CTRL_DEN_HIGH  = 4'hB;
  localparam int           TOC_LSB        = 4;
  localparam int           TOC_W          = 14;
  localparam int           CPF_LSB        = 18;
  localparam int           CPF_W          = 4;
  localparam int           CSR_LSB        = 22;
  localparam int           CSR_W          = 2;
  localparam int           DEN_HI_LSB     = 14;
  localparam int           DEN_HI_W       = 10;
  localparam int           DEN_LO_W       = 12;
  localparam int           DEN_W          = 22;
  localparam int           COUNT_W        = 15;
  localparam logic [13:0]  TOC_HIGH_Z     = 14'h0000;
  localparam logic [13:0]  TOC_MANUAL     = 14'h0001;
  localparam logic [13:0]  TOC_DRIVE_LOW  = 14'h0002;
  localparam logic [13:0]  TOC_DRIVE_HIGH = 14'h0003;
  localparam logic [13:0]  TOC_TIMED_MIN  = 14'h0004;
  localparam logic [13:0]  TOC_RESET      = 14'h0000;
  localparam logic [3:0]   CPF_RESET      = 4'h0;
  localparam logic [1:0]   CSR_RESET      = 2'h0;
  localparam logic [9:0]   DEN_HI_RESET   = 10'h000;
  localparam logic [3:0]   CSR_SHIFT_HALF = 4'h1;
  localparam logic [3:0]   CSR_SHIFT_QTR  = 4'h2;
  localparam logic [3:0]   CSR_SHIFT_16TH = 4'h4;
endpackage

module serial_word_rx
  import rf_fastlock_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              ser_clk,
  input  wire logic              ser_data,
  input  wire logic              ser_le,
  output logic                   word_valid,
  output logic [WORD_W-1:0]      word_data
);
  typedef struct packed {
    logic              clk_s1;
    logic              clk_s2;
    logic              clk_d;
    logic              dat_s1;
    logic              dat_s2;
    logic              le_s1;
    logic              le_s2;
    logic              le_d;
    logic [WORD_W-1:0] shift;
    logic [WORD_W-1:0] word;
    logic              valid;
  } rx_state_t;

  rx_state_t st_reg;
  rx_state_t st_next;

  always_comb begin
    st_next        = st_reg;
    st_next.clk_s1 = ser_clk;
    st_next.clk_s2 = st_reg.clk_s1;
    st_next.clk_d  = st_reg.clk_s2;
    st_next.dat_s1 = ser_data;
    st_next.dat_s2 = st_reg.dat_s1;
    st_next.le_s1  = ser_le;
    st_next.le_s2  = st_reg.le_s1;
    st_next.le_d   = st_reg.le_s2;
    st_next.valid  = 1'b0;
    // Bits arrive most significant first on each rising serial clock.
    if (st_reg.clk_s2 && !st_reg.clk_d) begin
      st_next.shift = {st_reg.shift[WORD_W-2:0], st_reg.dat_s2};
    end
    if (st_reg.le_s2 && !st_reg.le_d) begin
      st_next.word  = st_reg.shift;
      st_next.valid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign word_valid = st_reg.valid;
  assign word_data  = st_reg.word;
endmodule

`default_nettype wire

/* rf_fastlock_timeout_control.sv */
// Fastlock timeout, pin role, pump current, cycle slip and denominator control.
//
// Overview of operation
// - Width select low: denominator is the low twelve bits, upper ten ignored.
// - Width select high: denominator joins upper ten bits above low twelve.
// - Fourteen-bit timeout word governs fastlock and the fastlock pin role.
// - Timeout 0 to 3: timed fastlock off, pin is general tri-state output.
// - Timeout 4 to 16383: timed fastlock on, pin shows fastlock state.
// - Timed fastlock lasts twice the timeout in comparison cycles.
// - Code 1 forces fastlock, pin low; 0 high-Z, 2 low, 3 high.
// - Four-bit pump code n selects n+1 times unit current during fastlock.
// - Cycle slip code 0 off; 1, 2, 3 divide rate by 2, 4, 16.
`default_nettype none

module rf_fastlock_timeout_control
  import rf_fastlock_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  input  wire logic                ser_clk,
  input  wire logic                ser_data,
  input  wire logic                ser_le,
  input  wire logic                pd_cmp_clk,
  input  wire logic                frac_width_sel,
  input  wire logic [DEN_LO_W-1:0] rf_frac_den_low,
  output logic [DEN_W-1:0]         rf_frac_denominator,
  output logic                     fastlock_active,
  output logic                     fastlock_manual,
  output logic [CPF_W-1:0]         rf_fastlock_pump_current,
  output logic [CPF_W:0]           pump_multiplier,
  output logic                     cycle_slip_enable,
  output logic [3:0]               cycle_slip_rate_shift,
  output logic                     rf_fastlock_pin_out,
  output logic                     rf_fastlock_pin_oe
);
  typedef struct packed {
    logic [TOC_W-1:0]    toc;
    logic [CPF_W-1:0]    cpf;
    logic [CSR_W-1:0]    cycle_slip_reduction;
    logic [DEN_HI_W-1:0] den_hi;
    logic [DEN_W-1:0]    den;
    logic                timed;
    logic [COUNT_W-1:0]  count;
    logic                cmp_s1;
    logic                cmp_s2;
    logic                cmp_d;
    logic                pin_out;
    logic                pin_oe;
    logic [CPF_W:0]      mult;
    logic                slip_en;
    logic [3:0]          slip_shift;
  } ctl_state_t;

  ctl_state_t           st_reg;
  ctl_state_t           st_next;
  logic                 word_valid;
  logic [WORD_W-1:0]    word_data;
  logic                 cfg_write;
  logic                 den_write;
  logic                 cmp_edge;
  logic [TOC_W-1:0]     new_toc;

  serial_word_rx u_rx (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .ser_clk    (ser_clk),
    .ser_data   (ser_data),
    .ser_le     (ser_le),
    .word_valid (word_valid),
    .word_data  (word_data)
  );

  assign cfg_write = word_valid && (word_data[CTRL_W-1:0] == CTRL_FASTLOCK);
  assign den_write = word_valid && (word_data[CTRL_W-1:0] == CTRL_DEN_HIGH);
  assign cmp_edge  = st_reg.cmp_s2 && !st_reg.cmp_d;
  assign new_toc   = word_data[TOC_LSB +: TOC_W];

  always_comb begin
    st_next        = st_reg;
    st_next.cmp_s1 = pd_cmp_clk;
    st_next.cmp_s2 = st_reg.cmp_s1;
    st_next.cmp_d  = st_reg.cmp_s2;
    if (den_write) begin
      st_next.den_hi = word_data[DEN_HI_LSB +: DEN_HI_W];
    end
    if (frac_width_sel) begin
      st_next.den = {st_next.den_hi, rf_frac_den_low};
    end else begin
      st_next.den = {{DEN_HI_W{1'b0}}, rf_frac_den_low};
    end
    if (st_reg.timed && cmp_edge) begin
      if (st_reg.count <= 15'h0001) begin
        st_next.timed = 1'b0;
        st_next.count = '0;
      end else begin
        st_next.count = st_reg.count - 15'h0001;
      end
    end
    if (cfg_write) begin
      st_next.toc = new_toc;
      st_next.cpf = word_data[CPF_LSB +: CPF_W];
      st_next.cycle_slip_reduction = word_data[CSR_LSB +: CSR_W];
      // Timed fastlock starts with twice the timeout.
      if (new_toc >= TOC_TIMED_MIN) begin
        st_next.timed = 1'b1;
        st_next.count = {new_toc, 1'b0};
      end else begin
        st_next.timed = 1'b0;
        st_next.count = '0;
      end
    end
    // Pin role from the timeout word.
    case (st_next.toc)
      TOC_HIGH_Z: begin
        st_next.pin_oe  = 1'b0;
        st_next.pin_out = 1'b0;
      end
      TOC_MANUAL, TOC_DRIVE_LOW: begin
        st_next.pin_oe  = 1'b1;
        st_next.pin_out = 1'b0;
      end
      TOC_DRIVE_HIGH: begin
        st_next.pin_oe  = 1'b1;
        st_next.pin_out = 1'b1;
      end
      default: begin
        st_next.pin_oe  = 1'b1;
        st_next.pin_out = st_next.timed;
      end
    endcase
    // Pump multiplier is code plus one while fastlock holds.
    if (st_next.timed || (st_next.toc == TOC_MANUAL)) begin
      st_next.mult = {1'b0, st_next.cpf} + 5'h01;
    end else begin
      st_next.mult = 5'h00;
    end
    st_next.slip_en = (st_next.cycle_slip_reduction != 2'h0);
    case (st_next.cycle_slip_reduction)
      2'h1:    st_next.slip_shift = CSR_SHIFT_HALF;
      2'h2:    st_next.slip_shift = CSR_SHIFT_QTR;
      2'h3:    st_next.slip_shift = CSR_SHIFT_16TH;
      default: st_next.slip_shift = 4'h0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_reg        <= '0;
      st_reg.toc    <= TOC_RESET;
      st_reg.cpf    <= CPF_RESET;
      st_reg.cycle_slip_reduction    <= CSR_RESET;
      st_reg.den_hi <= DEN_HI_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rf_frac_denominator      = st_reg.den;
  assign fastlock_manual          = (st_reg.toc == TOC_MANUAL);
  assign fastlock_active          = st_reg.timed || fastlock_manual;
  assign rf_fastlock_pump_current = st_reg.cpf;
  assign pump_multiplier          = st_reg.mult;
  assign cycle_slip_enable        = st_reg.slip_en;
  assign cycle_slip_rate_shift    = st_reg.slip_shift;
  assign rf_fastlock_pin_out      = st_reg.pin_out;
  assign rf_fastlock_pin_oe       = st_reg.pin_oe;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_timed_load;
    cfg_write && (new_toc >= TOC_TIMED_MIN);
  endsequence

  sequence s_last_cycle;
    st_reg.timed && cmp_edge && (st_reg.count == 15'h0001) && !cfg_write;
  endsequence

  // The reset edge itself is left out: the register clears there while the low field may already be set.
  chk_den_narrow: assert property (nrst && !frac_width_sel |=>
      rf_frac_denominator == {10'h000, $past(rf_frac_den_low)})
    else $error("narrow denominator wrong");
  chk_den_wide: assert property (nrst && frac_width_sel && !den_write |=>
      rf_frac_denominator == {$past(st_reg.den_hi), $past(rf_frac_den_low)})
    else $error("wide denominator wrong");
  chk_gp_role: assert property (st_reg.toc < TOC_TIMED_MIN |-> !st_reg.timed)
    else $error("timed fastlock with general purpose code");
  chk_timed_start: assert property (s_timed_load |=> st_reg.timed && st_reg.count == {$past(new_toc), 1'b0}
      && rf_fastlock_pin_oe && rf_fastlock_pin_out)
    else $error("timed fastlock did not start with twice the timeout");
  chk_pin_codes: assert property ((st_reg.toc == TOC_HIGH_Z) |-> !rf_fastlock_pin_oe ##0
      1'b1)
    else $error("code 0 pin not high impedance");
  chk_pin_high: assert property ((st_reg.toc == TOC_DRIVE_HIGH) |-> rf_fastlock_pin_oe && rf_fastlock_pin_out)
    else $error("code 3 pin not driven high");
  chk_manual_mode: assert property ((st_reg.toc == TOC_MANUAL) |-> fastlock_active && !rf_fastlock_pin_out
      && rf_fastlock_pin_oe)
    else $error("manual mode not forced");
  chk_pin_follows: assert property ((st_reg.toc >= TOC_TIMED_MIN) |-> rf_fastlock_pin_out == st_reg.timed)
    else $error("fastlock pin does not follow state");
  chk_expiry_exit: assert property (s_last_cycle |=> !st_reg.timed && !rf_fastlock_pin_out
      && pump_multiplier == 5'h00)
    else $error("fastlock did not end on expiry");
  chk_pump_mult: assert property (fastlock_active |-> pump_multiplier == {1'b0, st_reg.cpf} + 5'h01)
    else $error("pump multiplier wrong");
  chk_slip_rate: assert property (cfg_write && word_data[CSR_LSB +: CSR_W] == 2'h3 |=>
      cycle_slip_enable && cycle_slip_rate_shift == CSR_SHIFT_16TH)
    else $error("cycle slip sixteenth rate wrong");
  chk_word_latch: assert property (cfg_write |=> st_reg.toc == $past(new_toc)
      && st_reg.cpf == $past(word_data[CPF_LSB +: CPF_W]))
    else $error("configuration word not latched");
endmodule

`default_nettype wire

/* serial_host.sv */
// Host model that shifts configuration words into the three-wire serial port.
`default_nettype none
module serial_host (
  input  wire logic ref_clk,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      ser_le
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_le = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      ser_data <= w[i];
      hold(4);
      ser_clk <= 1'b1;
      hold(4);
      ser_clk <= 1'b0;
    end
    hold(4);
    ser_le <= 1'b1;
    hold(4);
    ser_le <= 1'b0;
    // Data line no longer holds the last bit once the frame is over.
    ser_data <= ~ser_data;
    hold(4);
  endtask
endmodule
`default_nettype wire

/* rf_fastlock_timeout_control_bench.sv */
// Self-checking bench for the fastlock timeout control block.
`default_nettype none
module rf_fastlock_timeout_control_bench
  import rf_fastlock_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                ref_clk = 1'b0;
  logic                nrst = 1'b0;
  logic                pd_cmp_clk = 1'b0;
  logic                frac_width_sel = 1'b0;
  logic [DEN_LO_W-1:0] rf_frac_den_low = '0;
  logic                ser_clk, ser_data, ser_le;
  logic [DEN_W-1:0]    den;
  logic                act, man, slip_en, pin_out, pin_oe;
  logic [CPF_W-1:0]    cur;
  logic [CPF_W:0]      mult;
  logic [3:0]          shift;
  int                  error_cnt = 0;
  int                  samples_checked = 0;
  int                  seed = 73;
  int                  toc = 0, cpf = 0, cycle_slip_reduction = 0, hi = 0, cnt = 0;
  always #5 ref_clk = ~ref_clk;
  serial_host host (.ref_clk(ref_clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le));
  rf_fastlock_timeout_control dut (
    .ref_clk                  (ref_clk),
    .nrst                     (nrst),
    .ser_clk                  (ser_clk),
    .ser_data                 (ser_data),
    .ser_le                   (ser_le),
    .pd_cmp_clk               (pd_cmp_clk),
    .frac_width_sel           (frac_width_sel),
    .rf_frac_den_low          (rf_frac_den_low),
    .rf_frac_denominator      (den),
    .fastlock_active          (act),
    .fastlock_manual          (man),
    .rf_fastlock_pump_current (cur),
    .pump_multiplier          (mult),
    .cycle_slip_enable        (slip_en),
    .cycle_slip_rate_shift    (shift),
    .rf_fastlock_pin_out      (pin_out),
    .rf_fastlock_pin_oe       (pin_oe)
  );
  task automatic report_and_stop();
    if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input string n, input int e, input logic [21:0] g);
    samples_checked++;
    if (g !== 22'(e)) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, 22'(e), g);
    end
  endtask
  task automatic check_all();
    int on;
    @(negedge ref_clk);
    on = (toc >= 4 && cnt > 0) || toc == 1;
    cmp("active", on, act);
    cmp("manual", toc == 1, man);
    cmp("pump code", cpf, cur);
    cmp("multiplier", on ? cpf + 1 : 0, mult);
    cmp("slip enable", cycle_slip_reduction != 0, slip_en);
    cmp("slip shift", cycle_slip_reduction == 3 ? 4 : cycle_slip_reduction, shift);
    cmp("pin oe", toc != 0, pin_oe);
    cmp("pin out", toc == 3 || (toc >= 4 && cnt > 0), pin_out);
    cmp("denominator", frac_width_sel ? hi * 4096 + rf_frac_den_low : rf_frac_den_low, den);
    @(posedge ref_clk);
  endtask
  task automatic write_cfg(input int t, input int c, input int s);
    host.send({2'(s), 4'(c), 14'(t), CTRL_FASTLOCK});
    toc = t;
    cpf = c;
    cycle_slip_reduction = s;
    cnt = 2 * t;
    check_all();
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      pd_cmp_clk <= 1'b1;
      repeat (3) @(posedge ref_clk);
      pd_cmp_clk <= 1'b0;
      repeat (3) @(posedge ref_clk);
      if (cnt > 0) cnt--;
    end
  endtask
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    check_all();
    for (int t = 0; t < 4; t++) write_cfg(t, $random(seed) & 15, t);
    host.send({20'hFFFFF, 4'h0});
    check_all();
    for (int k = 0; k < 3; k++) begin
      write_cfg(k == 0 ? 4 : 4 + ($random(seed) & 31), $random(seed) & 15, k);
      pulse(2 * toc - 1);
      check_all();
      pulse(1);
      check_all();
    end
    write_cfg(5, 15, 3);
    pulse(4);
    write_cfg(5, 15, 3);
    pulse(9);
    check_all();
    write_cfg(2, 7, 1);
    write_cfg(16383, 15, 2);
    for (int k = 0; k < 4; k++) begin
      hi = $random(seed) & 1023;
      host.send({10'(hi), 10'(0), CTRL_DEN_HIGH});
      frac_width_sel <= k[0];
      rf_frac_den_low <= 12'($random(seed));
      repeat (2) @(posedge ref_clk);
      check_all();
    end
    // A reset in mid-run must clear every setting, the upper denominator bits included.
    nrst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    toc = 0;
    cpf = 0;
    cycle_slip_reduction = 0;
    cnt = 0;
    hi = 0;
    @(posedge ref_clk);
    check_all();
    report_and_stop();
  end
endmodule
`default_nettype wire
